// ### design/pllcfg_top.sv
// Purpose: configuration bank of the first PLL, reached over APB
// Assumes: control pins are asynchronous; pclk is the only clock
// Notes: settings are indexed by the synchronised control-pin state
// Notes on behaviour
// - eight 3-bit spread codes; the one indexed by pin state drives modulation
// - spread code decodes to 0, 0.25 ... 1.5, 2.0 percent
// - direction bit: clear is down spread, set is center spread
// - one vco set bit per state, eight in all; clear picks set zero, set picks one
// - three control pins select one of eight predefined settings
// - bypass bit, reset one: clear routes pll, set bypasses and powers down
// - output b mux: clear post divider one, set post divider two
// - output c mux: 00 one, 01 two, 10 three, 11 reserved; reset 10
// - state def: 00 hi-z and pll down, 01 hi-z, 10 low, 11 on
// - per-state select bit picks state def zero or one for outputs b, c
// - post divider zero is reset and standby; 1..127 divides by value
// - register bytes carry their most significant bit first
`timescale 1ns/10ps
`include "pllcfg_regs.svh"

module pllcfg_top
	import pllcfg_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// control pins
	input wire logic control_pin_zero,
	input wire logic control_pin_one,
	input wire logic control_pin_two,
	// modulation and vco selection
	output logic [2:0] spread_amount_code,
	output logic [7:0] spread_amount_hundredths,
	output logic spread_direction_bit,
	output logic vco_set_select_bit,
	// pll and output control
	output logic pll_bypass_select,
	output logic pll_power_down,
	output logic out_b_data,
	output logic out_b_oe,
	output logic out_c_data,
	output logic out_c_oe,
	output logic [2:0] divider_standby
);

	pllcfg_state_s st;
	pllcfg_state_s next_st;

	logic [7:0] index;
	logic upper_zero;
	logic access_phase;
	logic [2:0] ticks;
	pllcfg_div_t divisors [3];

	pllcfg_div_if div_bus [3] ();

	// true for every index that the bank answers
	function automatic logic reg_hit(input logic [7:0] i);
		case (i)
			`PLLCFG_IDX_SPREAD_UP,
			`PLLCFG_IDX_SPREAD_MID,
			`PLLCFG_IDX_SPREAD_LOW,
			`PLLCFG_IDX_VCO_SEL,
			`PLLCFG_IDX_MUX_STATES,
			`PLLCFG_IDX_PAIR_SEL,
			`PLLCFG_IDX_DIR_DIV_TWO,
			`PLLCFG_IDX_DIV_THREE,
			`PLLCFG_IDX_DIV_ONE,
			`PLLCFG_IDX_STATUS,
			`PLLCFG_IDX_STATUS_OUT: reg_hit = 1'b1;
			default: reg_hit = 1'b0;
		endcase
	endfunction

	// one bit of a per-state byte, chosen by the pin index
	function automatic logic pick_bit(input logic [7:0] v, input logic [2:0] i);
		pick_bit = v[i];
	endfunction

	// spread code of state i; state seven sits in the top three bits
	function automatic pllcfg_code_t pick_code(input logic [23:0] v, input logic [2:0] i);
		logic [4:0] lsb;
		lsb = 5'(i) * 5'd3;
		pick_code = v[lsb +: 3];
	endfunction

	// modulation amount in hundredths of a percent
	function automatic logic [7:0] spread_amount(input pllcfg_code_t c);
		case (c)
			3'h0: spread_amount = 8'h00;
			3'h1: spread_amount = 8'h19;
			3'h2: spread_amount = 8'h32;
			3'h3: spread_amount = 8'h4B;
			3'h4: spread_amount = 8'h64;
			3'h5: spread_amount = 8'h7D;
			3'h6: spread_amount = 8'h96;
			3'h7: spread_amount = 8'hC8;
			default: spread_amount = 8'h00;
		endcase
	endfunction

	// register byte as software reads it; bit 7 is the byte's msb
	function automatic logic [7:0] read_byte(input pllcfg_state_s s, input logic [7:0] i,
			input logic [2:0] stb);
		case (i)
			`PLLCFG_IDX_SPREAD_UP: read_byte = s.spread[23:16];
			`PLLCFG_IDX_SPREAD_MID: read_byte = s.spread[15:8];
			`PLLCFG_IDX_SPREAD_LOW: read_byte = s.spread[7:0];
			`PLLCFG_IDX_VCO_SEL: read_byte = s.vco_sel;
			`PLLCFG_IDX_MUX_STATES: read_byte = s.mux_states;
			`PLLCFG_IDX_PAIR_SEL: read_byte = s.pair_sel;
			`PLLCFG_IDX_DIR_DIV_TWO: read_byte = {s.dir, s.div_two};
			`PLLCFG_IDX_DIV_THREE: read_byte = {1'b0, s.div_three};
			`PLLCFG_IDX_DIV_ONE: read_byte = {1'b0, s.div_one};
			`PLLCFG_IDX_STATUS: read_byte = {s.out_vco, s.out_code, 1'b0, s.idx};
			`PLLCFG_IDX_STATUS_OUT: read_byte = {s.out_bypass, s.out_pd, s.out_b_oe,
					s.out_c_oe, s.out_center, stb};
			default: read_byte = 8'h00;
		endcase
	endfunction

	assign index = paddr[9:2];
	assign upper_zero = (paddr[ADDR_W-1:10] == '0);
	assign access_phase = psel && penable;

	always_comb begin
		logic [2:0] pins;
		logic [1:0] def;
		logic src_b;
		logic src_c;
		logic pd_by_def;
		pins = {control_pin_two, control_pin_one, control_pin_zero};
		def = 2'h0;
		src_b = 1'b0;
		src_c = 1'b0;
		pd_by_def = 1'b0;
		next_st = st;

		// three-stage pin synchroniser; index moves once stages two and three agree
		next_st.pin_s1 = pins;
		next_st.pin_s2 = st.pin_s1;
		next_st.pin_s3 = st.pin_s2;
		if (st.pin_s2 == st.pin_s3) begin
			next_st.idx = st.pin_s3;
		end

		// read data is captured in the setup cycle so that the access phase needs no wait
		if (psel && !penable && !pwrite) begin
			if (upper_zero && reg_hit(index)) begin
				next_st.prdata = {24'h000000, read_byte(st, index, divider_standby)};
			end else begin
				next_st.prdata = 32'h00000000;
			end
		end

		// writes land only on the access edge and only on byte lane zero
		if (access_phase && pwrite && upper_zero && pstrb[0]) begin
			case (index)
				`PLLCFG_IDX_SPREAD_UP: next_st.spread[23:16] = pwdata[7:0];
				`PLLCFG_IDX_SPREAD_MID: next_st.spread[15:8] = pwdata[7:0];
				`PLLCFG_IDX_SPREAD_LOW: next_st.spread[7:0] = pwdata[7:0];
				`PLLCFG_IDX_VCO_SEL: next_st.vco_sel = pwdata[7:0];
				`PLLCFG_IDX_MUX_STATES: next_st.mux_states = pwdata[7:0];
				`PLLCFG_IDX_PAIR_SEL: next_st.pair_sel = pwdata[7:0];
				`PLLCFG_IDX_DIR_DIV_TWO: begin
					next_st.dir = pwdata[`PLLCFG_BIT_DIR];
					next_st.div_two = pwdata[`PLLCFG_DIV_HI:0];
				end
				`PLLCFG_IDX_DIV_THREE: next_st.div_three = pwdata[`PLLCFG_DIV_HI:0];
				`PLLCFG_IDX_DIV_ONE: next_st.div_one = pwdata[`PLLCFG_DIV_HI:0];
				// status and unmapped indices, 40h and above among them, are never stored
				default: begin
				end
			endcase
		end

		// active setting of the present control state
		next_st.out_code = pick_code(st.spread, st.idx);
		next_st.out_amount = spread_amount(pick_code(st.spread, st.idx));
		next_st.out_center = st.dir;
		next_st.out_vco = pick_bit(st.vco_sel, st.idx);
		next_st.out_bypass = st.mux_states[`PLLCFG_BIT_BYPASS];

		// state definition one or zero for the output pair
		if (pick_bit(st.pair_sel, st.idx)) begin
			def = st.mux_states[`PLLCFG_DEF_ONE_HI:`PLLCFG_DEF_ONE_LO];
		end else begin
			def = st.mux_states[`PLLCFG_DEF_ZERO_HI:`PLLCFG_DEF_ZERO_LO];
		end

		// output b source
		if (st.mux_states[`PLLCFG_BIT_OUTB_MUX]) begin
			src_b = ticks[1];
		end else begin
			src_b = ticks[0];
		end

		// output c source; the reserved code gives a quiet output
		case (st.mux_states[`PLLCFG_OUTC_MUX_HI:`PLLCFG_OUTC_MUX_LO])
			`PLLCFG_OUTC_DIV_ONE: src_c = ticks[0];
			`PLLCFG_OUTC_DIV_TWO: src_c = ticks[1];
			`PLLCFG_OUTC_DIV_THREE: src_c = ticks[2];
			default: src_c = 1'b0;
		endcase

		// output pair drive from the chosen definition
		case (def)
			`PLLCFG_OST_HIZ_PD: begin
				next_st.out_b_oe = 1'b0;
				next_st.out_c_oe = 1'b0;
				next_st.out_b_data = 1'b0;
				next_st.out_c_data = 1'b0;
				pd_by_def = 1'b1;
			end
			`PLLCFG_OST_HIZ: begin
				next_st.out_b_oe = 1'b0;
				next_st.out_c_oe = 1'b0;
				next_st.out_b_data = 1'b0;
				next_st.out_c_data = 1'b0;
			end
			`PLLCFG_OST_LOW: begin
				next_st.out_b_oe = 1'b1;
				next_st.out_c_oe = 1'b1;
				next_st.out_b_data = 1'b0;
				next_st.out_c_data = 1'b0;
			end
			default: begin
				next_st.out_b_oe = 1'b1;
				next_st.out_c_oe = 1'b1;
				next_st.out_b_data = src_b;
				next_st.out_c_data = src_c;
			end
		endcase

		// the pll sleeps when bypassed or when the pair definition asks for it
		next_st.out_pd = st.mux_states[`PLLCFG_BIT_BYPASS] || pd_by_def;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '{
				pin_s1: 3'h0,
				pin_s2: 3'h0,
				pin_s3: 3'h0,
				idx: 3'h0,
				spread: `PLLCFG_RST_SPREAD,
				vco_sel: `PLLCFG_RST_VCO_SEL,
				mux_states: `PLLCFG_RST_MUX_STATES,
				pair_sel: `PLLCFG_RST_PAIR_SEL,
				dir: `PLLCFG_RST_DIR,
				div_one: `PLLCFG_RST_DIV_ONE,
				div_two: `PLLCFG_RST_DIV_TWO,
				div_three: `PLLCFG_RST_DIV_THREE,
				prdata: 32'h00000000,
				out_code: 3'h0,
				out_amount: 8'h00,
				out_center: 1'b0,
				out_vco: 1'b0,
				out_bypass: 1'b1,
				out_pd: 1'b1,
				out_b_data: 1'b0,
				out_b_oe: 1'b0,
				out_c_data: 1'b0,
				out_c_oe: 1'b0
			};
		end else begin
			st <= next_st;
		end
	end

	// post dividers
	assign divisors[0] = st.div_one;
	assign divisors[1] = st.div_two;
	assign divisors[2] = st.div_three;

	for (genvar g = 0; g < 3; g++) begin : g_div
		assign div_bus[g].divisor = divisors[g];
		assign ticks[g] = div_bus[g].tick;
		assign divider_standby[g] = div_bus[g].standby;
		pllcfg_post_div u_div (
			.pclk(pclk),
			.presetn(presetn),
			.bus(div_bus[g])
		);
	end

	// zero-wait slave; the host keeps below 40h, anything unmapped is answered with an error
	assign pready = 1'b1;
	assign pslverr = access_phase && !(upper_zero && reg_hit(index));
	assign prdata = st.prdata;

	assign spread_amount_code = st.out_code;
	assign spread_amount_hundredths = st.out_amount;
	assign spread_direction_bit = st.out_center;
	assign vco_set_select_bit = st.out_vco;
	assign pll_bypass_select = st.out_bypass;
	assign pll_power_down = st.out_pd;
	assign out_b_data = st.out_b_data;
	assign out_b_oe = st.out_b_oe;
	assign out_c_data = st.out_c_data;
	assign out_c_oe = st.out_c_oe;

endmodule

// ### design/pllcfg_regs.svh
// Purpose: register indices, reset values, field positions and codes of the PLL config bank
// Assumes: byte address of a register is four times its index
// Notes: definitions only
`ifndef PLLCFG_REGS_SVH
`define PLLCFG_REGS_SVH

// register indices
`define PLLCFG_IDX_SPREAD_UP 8'h10
`define PLLCFG_IDX_SPREAD_MID 8'h11
`define PLLCFG_IDX_SPREAD_LOW 8'h12
`define PLLCFG_IDX_VCO_SEL 8'h13
`define PLLCFG_IDX_MUX_STATES 8'h14
`define PLLCFG_IDX_PAIR_SEL 8'h15
`define PLLCFG_IDX_DIR_DIV_TWO 8'h16
`define PLLCFG_IDX_DIV_THREE 8'h17
`define PLLCFG_IDX_DIV_ONE 8'h20
`define PLLCFG_IDX_STATUS 8'h21
`define PLLCFG_IDX_STATUS_OUT 8'h22

// reset values
`define PLLCFG_RST_SPREAD 24'h000000
`define PLLCFG_RST_VCO_SEL 8'h00
`define PLLCFG_RST_MUX_STATES 8'hED
`define PLLCFG_RST_PAIR_SEL 8'h02
`define PLLCFG_RST_DIR 1'b0
`define PLLCFG_RST_DIV_ONE 7'h01
`define PLLCFG_RST_DIV_TWO 7'h01
`define PLLCFG_RST_DIV_THREE 7'h01

// field positions in the mux and output state register, then in the direction and divider registers
`define PLLCFG_BIT_BYPASS 7
`define PLLCFG_BIT_OUTB_MUX 6
`define PLLCFG_OUTC_MUX_HI 5
`define PLLCFG_OUTC_MUX_LO 4
`define PLLCFG_DEF_ONE_HI 3
`define PLLCFG_DEF_ONE_LO 2
`define PLLCFG_DEF_ZERO_HI 1
`define PLLCFG_DEF_ZERO_LO 0
`define PLLCFG_BIT_DIR 7
`define PLLCFG_DIV_HI 6

// output state definition codes
`define PLLCFG_OST_HIZ_PD 2'h0
`define PLLCFG_OST_HIZ 2'h1
`define PLLCFG_OST_LOW 2'h2
`define PLLCFG_OST_ON 2'h3

// output c source codes
`define PLLCFG_OUTC_DIV_ONE 2'h0
`define PLLCFG_OUTC_DIV_TWO 2'h1
`define PLLCFG_OUTC_DIV_THREE 2'h2

`define PLLCFG_NUM_STATES 8
`define PLLCFG_CODE_W 3
`define PLLCFG_DIV_W 7

`endif

// ### design/pllcfg_pkg.sv
// Purpose: shared types of the PLL config bank
// Assumes: pllcfg_regs.svh supplies widths
// Notes: one packed struct per module holds all state
`include "pllcfg_regs.svh"

package pllcfg_pkg;

	typedef logic [`PLLCFG_DIV_W-1:0] pllcfg_div_t;
	typedef logic [`PLLCFG_CODE_W-1:0] pllcfg_code_t;

	typedef struct packed {
		pllcfg_div_t count;
		logic tick;
		logic standby;
	} pllcfg_div_s;

	typedef struct packed {
		logic [2:0] pin_s1;
		logic [2:0] pin_s2;
		logic [2:0] pin_s3;
		logic [2:0] idx;
		logic [23:0] spread;
		logic [7:0] vco_sel;
		logic [7:0] mux_states;
		logic [7:0] pair_sel;
		logic dir;
		pllcfg_div_t div_one;
		pllcfg_div_t div_two;
		pllcfg_div_t div_three;
		logic [31:0] prdata;
		pllcfg_code_t out_code;
		logic [7:0] out_amount;
		logic out_center;
		logic out_vco;
		logic out_bypass;
		logic out_pd;
		logic out_b_data;
		logic out_b_oe;
		logic out_c_data;
		logic out_c_oe;
	} pllcfg_state_s;

endpackage

// ### design/pllcfg_div_if.sv
// Purpose: carries divisor and divider status between the bank and a post divider
// Assumes: single clock domain
// Notes: none
`timescale 1ns/10ps

interface pllcfg_div_if;
	import pllcfg_pkg::*;
	pllcfg_div_t divisor;
	logic tick;
	logic standby;
	modport ctrl (output divisor, input tick, input standby);
	modport div (input divisor, output tick, output standby);
endinterface

// ### design/pllcfg_post_div.sv
// Purpose: one 7-bit post divider, a tick every divisor cycles of pclk
// Assumes: divisor may change at any time
// Notes: divisor zero holds the divider in reset and standby
`timescale 1ns/10ps

module pllcfg_post_div
	import pllcfg_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// divisor in, tick out
	pllcfg_div_if.div bus
);

	pllcfg_div_s st;
	pllcfg_div_s next_st;

	always_comb begin
		next_st = st;
		if (bus.divisor == '0) begin
			// zero divisor: reset and standby
			next_st.count = '0;
			next_st.tick = 1'b0;
			next_st.standby = 1'b1;
		end else begin
			next_st.standby = 1'b0;
			// >= so that a divisor lowered mid-count wraps at once
			if (st.count >= bus.divisor - 7'h01) begin
				next_st.count = '0;
				next_st.tick = 1'b1;
			end else begin
				next_st.count = st.count + 7'h01;
				next_st.tick = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '{count: '0, tick: 1'b0, standby: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign bus.tick = st.tick;
	assign bus.standby = st.standby;

endmodule

// ### tb/pllcfg_top_monitor.sv
// Purpose: bus and output relations of the pll config bank
// Assumes: only the top ports are seen
// Notes: bound into pllcfg_top
`timescale 1ns/10ps

module pllcfg_top_monitor #(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pslverr,
	// outputs
	input wire logic [2:0] spread_amount_code,
	input wire logic [7:0] spread_amount_hundredths,
	input wire logic pll_bypass_select,
	input wire logic pll_power_down,
	input wire logic out_b_data,
	input wire logic out_b_oe,
	input wire logic out_c_data,
	input wire logic out_c_oe,
	input wire logic [2:0] divider_standby
);
	localparam logic [7:0] HUND [8] = '{8'h00, 8'h19, 8'h32, 8'h4B, 8'h64, 8'h7D, 8'h96, 8'hC8};

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_err_in_access: assert property (pslverr |-> psel && penable)
		else $error("error response outside access phase");
	a_err_high_addr: assert property (
		psel && penable && paddr[ADDR_W-1:10] != 0 |-> pslverr)
		else $error("high address not refused");
	a_amount_decode: assert property (
		spread_amount_hundredths == HUND[spread_amount_code])
		else $error("spread amount decode wrong");
	a_bypass_powers_down: assert property (pll_bypass_select |-> pll_power_down)
		else $error("bypass without power down");
	a_b_data_oe: assert property (out_b_data |-> out_b_oe)
		else $error("output b toggles while not driven");
	a_c_data_oe: assert property (out_c_data |-> out_c_oe)
		else $error("output c toggles while not driven");
	a_div_zero_standby: assert property (
		psel && penable && pwrite && pstrb[0]
		&& paddr == 'h58 && pwdata[6:0] == 7'h00 |-> ##[1:3] divider_standby[1])
		else $error("zero divisor not in standby");
	a_write_bypass: assert property (
		psel && penable && pwrite && pstrb[0] && paddr == 'h50
		|-> ##2 pll_bypass_select == $past(pwdata[7], 2))
		else $error("bypass select does not follow write");
endmodule

bind pllcfg_top pllcfg_top_monitor #(.ADDR_W(ADDR_W)) mon (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .pslverr(pslverr), .spread_amount_code(spread_amount_code),
	.spread_amount_hundredths(spread_amount_hundredths), .pll_bypass_select(pll_bypass_select),
	.pll_power_down(pll_power_down), .out_b_data(out_b_data), .out_b_oe(out_b_oe),
	.out_c_data(out_c_data), .out_c_oe(out_c_oe), .divider_standby(divider_standby));

// ### tb/pllcfg_pin_host.sv
// Purpose: outside party driving the three control pins
// Assumes: pins change just after a rising edge
// Notes: pins are asynchronous to the bank
`timescale 1ns/10ps

module pllcfg_pin_host (
	// clock
	input wire logic pclk,
	// control pins
	output logic control_pin_zero,
	output logic control_pin_one,
	output logic control_pin_two
);
	initial begin
		{control_pin_two, control_pin_one, control_pin_zero} = 3'h0;
	end

	// all three pins move together so no stray index is ever presented
	task automatic set_index(input logic [2:0] x);
		@(posedge pclk);
		{control_pin_two, control_pin_one, control_pin_zero} <= x;
	endtask
endmodule

// ### tb/pllcfg_top_tb.sv
// Purpose: self-checking bench of the pll config bank
// Assumes: zero wait state apb slave, pins synchronised in the bank
// Notes: pstrb lowered once to show that a write without lane zero is dropped
`timescale 1ns/10ps
`include "pllcfg_regs.svh"

module pllcfg_top_tb;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] pstrb = 4'hF;
	logic pready, pslverr, err, dir, vco, byp, pd, bd, boe, cd, coe, p0, p1, p2;
	logic [2:0] code, stby;
	logic [7:0] hund;
	int n_mismatch = 0, tests_run = 0, cnt = 0;
	localparam logic [7:0] HUND [8] = '{8'h00, 8'h19, 8'h32, 8'h4B, 8'h64, 8'h7D, 8'h96, 8'hC8};
	localparam logic [7:0] RADR [9] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17,
		8'h20};
	localparam logic [7:0] RVAL [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hED, 8'h02, 8'h01, 8'h01,
		8'h01};

	always #50 pclk = ~pclk;

	pllcfg_pin_host ph (.pclk(pclk), .control_pin_zero(p0), .control_pin_one(p1),
		.control_pin_two(p2));

	pllcfg_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .control_pin_zero(p0), .control_pin_one(p1),
		.control_pin_two(p2), .spread_amount_code(code), .spread_amount_hundredths(hund),
		.spread_direction_bit(dir), .vco_set_select_bit(vco), .pll_bypass_select(byp),
		.pll_power_down(pd), .out_b_data(bd), .out_b_oe(boe), .out_c_data(cd), .out_c_oe(coe),
		.divider_standby(stby));

	function automatic logic [11:0] ba(input logic [7:0] i);
		return {2'h0, i, 2'h0};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			n_mismatch++;
			$display("Error at %0t: no pready within 50 cycles", $time);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// outputs follow a write one edge after it lands; three cycles leave margin
	task automatic setmux(input logic [7:0] d);
		apb(1'b1, ba(`PLLCFG_IDX_MUX_STATES), d);
		cyc(3);
	endtask

	task automatic end_sim;
		$display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		#1000000;
		n_mismatch++;
		end_sim;
	end

	initial begin
		cyc(3);
		presetn <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			apb(1'b0, ba(RADR[i]), 8'h00);
			chk(rd, {24'h0, RVAL[i]});
			chk(err, 0);
		end
		chk(byp, 1);
		apb(1'b1, ba(`PLLCFG_IDX_SPREAD_UP), 8'hFA);
		apb(1'b1, ba(`PLLCFG_IDX_SPREAD_MID), 8'hC6);
		apb(1'b1, ba(`PLLCFG_IDX_SPREAD_LOW), 8'h88);
		apb(1'b1, ba(`PLLCFG_IDX_VCO_SEL), 8'hA5);
		apb(1'b0, ba(`PLLCFG_IDX_SPREAD_MID), 8'h00);
		chk(rd, 32'hC6);
		for (int x = 0; x < 8; x++) begin
			ph.set_index(3'(x));
			cyc(8);
			chk(code, x);
			chk(hund, HUND[x]);
			chk(vco, (8'hA5 >> x) & 1);
		end
		ph.set_index(3'h0);
		cyc(8);
		apb(1'b1, ba(`PLLCFG_IDX_DIR_DIV_TWO), 8'h81);
		cyc(3);
		chk(dir, 1);
		for (int c = 0; c < 4; c++) begin
			setmux(8'(c));
			chk(boe, c / 2);
			chk(coe, c / 2);
			chk(pd, c == 0);
			chk(bd & cd, c == 3);
		end
		setmux(8'h33);
		chk({coe, cd}, 2'b10);
		setmux(8'h23);
		chk(cd, 1);
		apb(1'b1, ba(`PLLCFG_IDX_DIR_DIV_TWO), 8'h00);
		setmux(8'h43);
		chk(stby, 3'b010);
		chk(bd, 0);
		setmux(8'h03);
		chk(bd, 1);
		setmux(8'h0D);
		chk(boe, 0);
		apb(1'b1, ba(`PLLCFG_IDX_PAIR_SEL), 8'h01);
		cyc(3);
		chk(boe, 1);
		setmux(8'h8D);
		chk({byp, pd}, 2'b11);
		apb(1'b1, ba(`PLLCFG_IDX_DIV_THREE), 8'hFF);
		apb(1'b0, ba(`PLLCFG_IDX_DIV_THREE), 8'h00);
		chk(rd, 32'h7F);
		// lane zero strobe low: the write must be dropped without an error
		pstrb <= 4'hE;
		apb(1'b1, ba(`PLLCFG_IDX_DIV_THREE), 8'h03);
		pstrb <= 4'hF;
		chk(err, 0);
		apb(1'b0, ba(`PLLCFG_IDX_DIV_THREE), 8'h00);
		chk(rd, 32'h7F);
		// divide by three on output c: two ticks in any six cycles, sampled off the edge
		apb(1'b1, ba(`PLLCFG_IDX_DIV_THREE), 8'h03);
		setmux(8'h2F);
		cnt = 0;
		repeat (6) begin
			@(negedge pclk);
			cnt += cd;
		end
		chk(cnt, 2);
		apb(1'b1, 12'h400, 8'h55);
		chk(err, 1);
		apb(1'b0, ba(8'h18), 8'h00);
		chk({err, rd}, {1'b1, 32'h0});
		end_sim;
	end
endmodule
